// ---- gpa_pkg.sv ----
// constants for the eight-bit general-purpose port with its bus slave
package gpa_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [3:0] OFS_PIN_LEVEL    = 4'h0;
    localparam logic [3:0] OFS_DIRECTION    = 4'h4;
    localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h8;
    localparam logic [3:0] OFS_PORT_CONFIG  = 4'hc;

    // ==========================================================
    // port configuration fields
    localparam int CFG_ANALOG_LSB    = 0;
    localparam int CFG_OSC_IO        = 8;
    localparam int CFG_FAULT_SEL     = 9;
    localparam int CFG_SERIAL_EN     = 10;
    localparam int CFG_MRESET_EN     = 11;
    localparam int CFG_WIDTH         = 12;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_DIRECTION    = 8'hff;
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_ANALOG       = 8'h33;
    localparam logic       RST_OSC_IO       = 1'h1;
    localparam logic       RST_FAULT_SEL    = 1'h0;
    localparam logic       RST_SERIAL_EN    = 1'h0;
    localparam logic       RST_MRESET_EN    = 1'h1;

    // ==========================================================
    // pin masks
    localparam logic [7:0] ANALOG_CAPABLE   = 8'h33;
    localparam logic [7:0] OSC_PIN_MASK     = 8'hc0;
    localparam logic [7:0] INPUT_ONLY_MASK  = 8'h20;

    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage : gpa_pkg

// ---- gpa_sync2.sv ----
// two-stage synchronizer for the incoming pin levels
`timescale 1ns/1ps

module gpa_sync2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ==========================================================
    // stages
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage_one = async_in;
        next_sync_out  = stage_one;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= next_stage_one; // RULE16
            sync_out  <= next_sync_out;  // RULE16
        end
    end

endmodule : gpa_sync2

// ---- gpa_port.sv ----
// eight-bit general-purpose port with pin sharing and AXI4-Lite registers
`timescale 1ns/1ps

// Function
// RULE1: eight two-way pins, each with direction, level and latch bit
// RULE2: port runs from direction, pin-level and output-latch registers
// RULE3: direction bit one puts the pin driver in high impedance
// RULE4: direction bit zero drives the pin with its latch bit
// RULE5: pin-level read gives pin states; write to it loads the latch
// RULE6: latch register readable, returns latched value for safe updates
// RULE7: an enabled sharing peripheral takes the pin from port use
// RULE8: bits 6,7 oscillator or port by config; read zero when oscillator
// RULE9: config bit routes the PWM fault input from pin 5 or pin 7
// RULE10: reset makes pins 0,1,4,5 analog reading zero, 2,3 digital inputs
// RULE11: direction keeps driver control on analog pins; software keeps ones
// RULE12: analog enable cuts the digital input path, not the output; code masks only the pin-level read, irq/timer/fault/reset still see the pin
// RULE13: pin 0 feeds irq zero, change irq, analog, comparator; pin 1 similar
// RULE14: pins 2,3 serve the serial port; pin 4 feeds the timer clock
// RULE15: pin 5 is master reset, programming voltage and input only
// RULE16: pin levels pass a two-stage synchronizer before use
module gpa_port (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read address channel
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    // serial port side
    input  wire logic        serial_ck_tx_out,
    input  wire logic        serial_ck_tx_oe,
    input  wire logic        serial_dt_out,
    input  wire logic        serial_dt_oe,
    output logic             serial_ck_in,
    output logic             serial_rx_dt_in,
    // other shared functions
    output logic             ext_irq_zero,
    output logic             change_irq_zero,
    output logic             ext_irq_one,
    output logic             change_irq_one,
    output logic             timer0_ext_clock_in,
    output logic             pwm_fault_input,
    output logic             master_reset_n,
    output logic      [7:0]  analog_select
);

    // ==========================================================
    // register state
    logic [7:0]  direction_reg;
    logic [7:0]  output_latch_reg;
    logic [7:0]  analog_en;
    logic        osc_io_mode;
    logic        fault_pin_select;
    logic        serial_en;
    logic        mreset_en;
    logic [7:0]  next_direction_reg;
    logic [7:0]  next_output_latch_reg;
    logic [7:0]  next_analog_en;
    logic        next_osc_io_mode;
    logic        next_fault_pin_select;
    logic        next_serial_en;
    logic        next_mreset_en;

    // ==========================================================
    // bus state
    logic        aw_held;
    logic [3:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic [3:0]  next_aw_addr;
    logic        next_w_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // ==========================================================
    // pin-side values
    logic [7:0]  pin_sync;
    logic [7:0]  port_mask;
    logic [7:0]  level_view;
    logic [7:0]  next_pin_out;
    logic [7:0]  next_pin_oe;

    // ==========================================================
    // helpers
    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == gpa_pkg::OFS_PIN_LEVEL)
                   || (a == gpa_pkg::OFS_DIRECTION)
                   || (a == gpa_pkg::OFS_OUTPUT_LATCH)
                   || (a == gpa_pkg::OFS_PORT_CONFIG);
    endfunction : addr_mapped

    function automatic logic [3:0] word_offset(input logic [31:0] a);
        word_offset = (a[31:4] == 28'h0000000) ? {a[3:2], 2'h0} : 4'h1;
    endfunction : word_offset

    // ==========================================================
    // pin synchronizer
    gpa_sync2 #(
        .WIDTH    (8)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // ==========================================================
    // digital view of the port
    always_comb begin
        port_mask = osc_io_mode ? 8'hff : ~gpa_pkg::OSC_PIN_MASK; // RULE8
        level_view = pin_sync & ~analog_en & port_mask; // RULE12
    end

    // ==========================================================
    // write channel
    always_comb begin
        next_aw_held          = aw_held;
        next_aw_addr          = aw_addr;
        next_w_held           = w_held;
        next_w_data           = w_data;
        next_w_strb           = w_strb;
        next_bvalid           = s_axi_bvalid;
        next_bresp            = s_axi_bresp;
        next_direction_reg    = direction_reg;
        next_output_latch_reg = output_latch_reg;
        next_analog_en        = analog_en;
        next_osc_io_mode      = osc_io_mode;
        next_fault_pin_select = fault_pin_select;
        next_serial_en        = serial_en;
        next_mreset_en        = mreset_en;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = word_offset(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_mapped(aw_addr) ? gpa_pkg::RESP_OKAY
                                                : gpa_pkg::RESP_SLVERR;
            if (w_strb[0]) begin
                case (aw_addr)
                    gpa_pkg::OFS_PIN_LEVEL: begin
                        next_output_latch_reg = w_data[7:0]; // RULE5
                    end
                    gpa_pkg::OFS_DIRECTION: begin
                        next_direction_reg = w_data[7:0]; // RULE11
                    end
                    gpa_pkg::OFS_OUTPUT_LATCH: begin
                        next_output_latch_reg = w_data[7:0]; // RULE6
                    end
                    gpa_pkg::OFS_PORT_CONFIG: begin
                        next_analog_en = w_data[7:0]
                                       & gpa_pkg::ANALOG_CAPABLE;
                    end
                    default: begin
                        next_analog_en = analog_en;
                    end
                endcase
            end
            if (w_strb[1] && aw_addr == gpa_pkg::OFS_PORT_CONFIG) begin
                next_osc_io_mode      = w_data[gpa_pkg::CFG_OSC_IO];
                next_fault_pin_select = w_data[gpa_pkg::CFG_FAULT_SEL];
                next_serial_en        = w_data[gpa_pkg::CFG_SERIAL_EN];
                next_mreset_en        = w_data[gpa_pkg::CFG_MRESET_EN];
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    // ==========================================================
    // read channel
    always_comb begin
        logic [3:0] ra;
        ra          = word_offset(s_axi_araddr);
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = addr_mapped(ra) ? gpa_pkg::RESP_OKAY
                                          : gpa_pkg::RESP_SLVERR;
            case (ra)
                gpa_pkg::OFS_PIN_LEVEL: begin
                    next_rdata = {24'h000000, level_view}; // RULE5
                end
                gpa_pkg::OFS_DIRECTION: begin
                    next_rdata = {24'h000000, direction_reg & port_mask};
                end
                gpa_pkg::OFS_OUTPUT_LATCH: begin
                    next_rdata = {24'h000000,
                                  output_latch_reg & port_mask}; // RULE6
                end
                gpa_pkg::OFS_PORT_CONFIG: begin
                    next_rdata = {20'h00000, mreset_en, serial_en,
                                  fault_pin_select, osc_io_mode, analog_en};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // ==========================================================
    // pin drivers
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_pin_out[i] = output_latch_reg[i]; // RULE4
            next_pin_oe[i]  = !direction_reg[i]; // RULE3 RULE4 RULE12
        end
        next_pin_oe = next_pin_oe & port_mask; // RULE8
        next_pin_oe = next_pin_oe & ~gpa_pkg::INPUT_ONLY_MASK; // RULE15
        if (serial_en) begin
            next_pin_out[2] = serial_ck_tx_out; // RULE7 RULE14
            next_pin_oe[2]  = serial_ck_tx_oe; // RULE7 RULE14
            next_pin_out[3] = serial_dt_out; // RULE7 RULE14
            next_pin_oe[3]  = serial_dt_oe; // RULE7 RULE14
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direction_reg    <= gpa_pkg::RST_DIRECTION; // RULE10
            output_latch_reg <= gpa_pkg::RST_OUTPUT_LATCH;
            analog_en        <= gpa_pkg::RST_ANALOG; // RULE10
            osc_io_mode      <= gpa_pkg::RST_OSC_IO;
            fault_pin_select <= gpa_pkg::RST_FAULT_SEL;
            serial_en        <= gpa_pkg::RST_SERIAL_EN;
            mreset_en        <= gpa_pkg::RST_MRESET_EN;
            aw_held          <= 1'b0;
            aw_addr          <= 4'h0;
            w_held           <= 1'b0;
            w_data           <= 32'h00000000;
            w_strb           <= 4'h0;
            s_axi_awready    <= 1'b0;
            s_axi_wready     <= 1'b0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= gpa_pkg::RESP_OKAY;
            s_axi_arready    <= 1'b0;
            s_axi_rvalid     <= 1'b0;
            s_axi_rdata      <= 32'h00000000;
            s_axi_rresp      <= gpa_pkg::RESP_OKAY;
        end else begin
            direction_reg    <= next_direction_reg; // RULE2
            output_latch_reg <= next_output_latch_reg; // RULE2
            analog_en        <= next_analog_en;
            osc_io_mode      <= next_osc_io_mode;
            fault_pin_select <= next_fault_pin_select;
            serial_en        <= next_serial_en;
            mreset_en        <= next_mreset_en;
            aw_held          <= next_aw_held;
            aw_addr          <= next_aw_addr;
            w_held           <= next_w_held;
            w_data           <= next_w_data;
            w_strb           <= next_w_strb;
            s_axi_awready    <= next_awready;
            s_axi_wready     <= next_wready;
            s_axi_bvalid     <= next_bvalid;
            s_axi_bresp      <= next_bresp;
            s_axi_arready    <= next_arready;
            s_axi_rvalid     <= next_rvalid;
            s_axi_rdata      <= next_rdata;
            s_axi_rresp      <= next_rresp;
        end
    end

    // ==========================================================
    // pins and shared function outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out             <= 8'h00;
            pin_oe              <= 8'h00;
            serial_ck_in        <= 1'b0;
            serial_rx_dt_in     <= 1'b0;
            ext_irq_zero        <= 1'b0;
            change_irq_zero     <= 1'b0;
            ext_irq_one         <= 1'b0;
            change_irq_one      <= 1'b0;
            timer0_ext_clock_in <= 1'b0;
            pwm_fault_input     <= 1'b0;
            master_reset_n      <= 1'b1;
            analog_select       <= gpa_pkg::RST_ANALOG;
        end else begin
            pin_out             <= next_pin_out; // RULE1
            pin_oe              <= next_pin_oe; // RULE1
            serial_ck_in        <= pin_sync[2]; // RULE14
            serial_rx_dt_in     <= pin_sync[3]; // RULE14
            ext_irq_zero        <= pin_sync[0]; // RULE13
            change_irq_zero     <= pin_sync[0]; // RULE13
            ext_irq_one         <= pin_sync[1]; // RULE13
            change_irq_one      <= pin_sync[1]; // RULE13
            timer0_ext_clock_in <= pin_sync[4]; // RULE14
            pwm_fault_input     <= fault_pin_select ? pin_sync[7]
                                                    : pin_sync[5]; // RULE9
            master_reset_n      <= mreset_en ? pin_sync[5] : 1'b1; // RULE15
            analog_select       <= analog_en; // RULE13
        end
    end

endmodule : gpa_port

// ---- gpa_port_assertions.sv ----
// concurrent checks on the general-purpose port
`timescale 1ns/1ps

module gpa_port_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins and shared functions
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic        ext_irq_zero,
    input wire logic        change_irq_zero,
    input wire logic        ext_irq_one,
    input wire logic        timer0_ext_clock_in,
    input wire logic        pwm_fault_input,
    input wire logic        master_reset_n,
    input wire logic [7:0]  analog_select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // cycles since reset release, stops at four
    logic [2:0] up_cnt;
    logic [2:0] next_up_cnt;
    always_comb next_up_cnt = !aresetn ? 3'h0 :
        (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
    always_ff @(posedge aclk) up_cnt <= next_up_cnt;

    // ==========================================================
    // pins
    pin5_input_a: assert property (!pin_oe[5])
        else $error("pin 5 driven");
    analog_mask_a: assert property ((analog_select & 8'hcc) == 8'h00)
        else $error("analog enable on a digital-only pin");
    drive_commit_a: assert property (
        $changed({pin_oe, pin_out} & 16'hf3f3)
        |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("pin drive changed without a register write");
    sync_irq_a: assert property (up_cnt == 3'h4 |->
        ext_irq_zero == $past(pin_in[0], 3)
        && change_irq_zero == $past(pin_in[0], 3)
        && ext_irq_one == $past(pin_in[1], 3))
        else $error("irq inputs not fed by synced pins");
    timer_sync_a: assert property (up_cnt == 3'h4 |->
        timer0_ext_clock_in == $past(pin_in[4], 3))
        else $error("timer clock not fed by pin 4");
    fault_route_a: assert property (up_cnt == 3'h4 |->
        pwm_fault_input == $past(pin_in[5], 3)
        || pwm_fault_input == $past(pin_in[7], 3))
        else $error("fault input from neither pin");
    reset_pin_a: assert property (up_cnt == 3'h4 |->
        master_reset_n || !$past(pin_in[5], 3))
        else $error("reset input low with pin 5 high");

    // ==========================================================
    // register bus
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before accepted");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
endmodule : gpa_port_checker

bind gpa_port gpa_port_checker gpa_port_checker_i (.aclk, .aresetn,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .pin_in, .pin_out, .pin_oe, .ext_irq_zero,
    .change_irq_zero, .ext_irq_one, .timer0_ext_clock_in, .pwm_fault_input,
    .master_reset_n, .analog_select);

// ---- gpa_board.sv ----
// board model: external drivers and pull-ups on the port pins
`timescale 1ns/1ps

module gpa_board (
    // port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // board side
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_in
);
    // port driver wins, else board driver, else pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);
endmodule : gpa_board

// ---- tb_gpa_port.sv ----
// self-checking bench for the eight-bit general-purpose port
`timescale 1ns/1ps

module tb_gpa_port;
    // ==========================================================
    // signals
    localparam logic [31:0] A_LVL = {28'h0, gpa_pkg::OFS_PIN_LEVEL};
    localparam logic [31:0] A_DIR = {28'h0, gpa_pkg::OFS_DIRECTION};
    localparam logic [31:0] A_LAT = {28'h0, gpa_pkg::OFS_OUTPUT_LATCH};
    localparam logic [31:0] A_CFG = {28'h0, gpa_pkg::OFS_PORT_CONFIG};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  pin_in, pin_out, pin_oe, ext_val, ext_en, analog_select;
    logic        serial_ck_tx_out, serial_ck_tx_oe, serial_dt_out;
    logic        serial_dt_oe, serial_ck_in, serial_rx_dt_in, ext_irq_zero;
    logic        change_irq_zero, ext_irq_one, change_irq_one;
    logic        timer0_ext_clock_in, pwm_fault_input, master_reset_n;
    int          miscompares, checked;

    gpa_port gpa_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe, .serial_ck_tx_out, .serial_ck_tx_oe, .serial_dt_out,
        .serial_dt_oe, .serial_ck_in, .serial_rx_dt_in, .ext_irq_zero,
        .change_irq_zero, .ext_irq_one, .change_irq_one,
        .timer0_ext_clock_in, .pwm_fault_input, .master_reset_n,
        .analog_select);
    gpa_board gpa_board_i (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ==========================================================
    // compare, close and bus tasks
    task automatic chk(input string what, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chkp(input string what, input logic [7:0] e, g);
        chk(what, {24'h0, e}, {24'h0, g});
    endtask : chkp

    task automatic close_out;
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic lapse(input int n);
        if (n >= 100) begin
            miscompares++;
            close_out;
        end
    endtask : lapse

    task automatic wr(input logic [31:0] a, d, input logic [1:0] er = 2'h0);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        lapse(n);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [31:0] a, e, input logic [1:0] er = 2'h0);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        lapse(n);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd

    // ==========================================================
    // scenarios
    task automatic check_reset;
        rd(A_DIR, 32'hff);
        rd(A_LAT, 32'h00);
        rd(A_CFG, 32'h933);
        rd(A_LVL, 32'hcc);
        chkp("pin_oe", 8'h00, pin_oe);
        rd(32'h10, 32'h0, 2'h2);
        wr(32'h10, 32'hff, 2'h2);
        rd(A_LAT, 32'h00);
    endtask : check_reset

    task automatic drive_out;
        wr(A_CFG, 32'h100);
        wr(A_LAT, 32'h5a);
        wr(A_DIR, 32'h00);
        @(posedge aclk);
        chkp("pin_oe", 8'hdf, pin_oe);
        chkp("pin_out", 8'h5a, pin_out & 8'hdf);
        rd(A_LAT, 32'h5a);
        rd(A_LVL, 32'h7a);
        wr(A_LVL, 32'ha5);
        rd(A_LAT, 32'ha5);
        chkp("pin_out", 8'h85, pin_out & 8'hdf);
    endtask : drive_out

    task automatic read_in;
        wr(A_DIR, 32'hff);
        @(posedge aclk);
        chkp("pin_oe", 8'h00, pin_oe);
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        repeat (3) @(posedge aclk);
        rd(A_LVL, 32'h3c);
    endtask : read_in

    task automatic analog_pins;
        wr(A_CFG, 32'h133);
        rd(A_LVL, 32'h0c);
        chkp("analog_select", 8'h33, analog_select);
        ext_en <= 8'h00;
        wr(A_LAT, 32'h01);
        wr(A_DIR, 32'hfe);
        @(posedge aclk);
        chkp("pin_oe", 8'h01, pin_oe);
        chkp("pin_out0", 8'h01, {7'h0, pin_out[0]});
        wr(A_DIR, 32'hff);
    endtask : analog_pins

    task automatic osc_pins;
        wr(A_CFG, 32'h000);
        rd(A_DIR, 32'h3f);
        wr(A_LAT, 32'hc3);
        rd(A_LAT, 32'h03);
        rd(A_LVL, 32'h3f);
        wr(A_DIR, 32'h00);
        @(posedge aclk);
        chkp("pin_oe", 8'h1f, pin_oe);
    endtask : osc_pins

    task automatic shared_pins;
        wr(A_CFG, 32'hd00);
        wr(A_DIR, 32'hff);
        serial_ck_tx_oe <= 1'b1;
        serial_ck_tx_out <= 1'b1;
        serial_dt_oe <= 1'b1;
        ext_en <= 8'hfb;
        ext_val <= 8'hca;
        repeat (5) @(posedge aclk);
        chkp("pin_oe", 8'h0c, pin_oe);
        chkp("pin_out32", 8'h01, {6'h0, pin_out[3:2]});
        chkp("irq_pins", 8'h03, {4'h0, ext_irq_zero, change_irq_zero,
            ext_irq_one, change_irq_one});
        chkp("timer_serial", 8'h01, {5'h0, timer0_ext_clock_in,
            serial_rx_dt_in, serial_ck_in});
        chkp("fault_reset", 8'h00,
            {6'h0, pwm_fault_input, master_reset_n});
        wr(A_CFG, 32'h700);
        repeat (4) @(posedge aclk);
        chkp("fault_reset", 8'h03,
            {6'h0, pwm_fault_input, master_reset_n});
        serial_ck_tx_oe <= 1'b0;
        serial_dt_oe <= 1'b0;
        ext_en <= 8'h00;
    endtask : shared_pins

    task automatic reset_again;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CFG, 32'h933);
        rd(A_LAT, 32'h00);
    endtask : reset_again

    // ==========================================================
    // main sequence
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {serial_ck_tx_out, serial_ck_tx_oe, serial_dt_out} = '0;
        {serial_dt_oe, ext_val, ext_en, aresetn} = '0;
        s_axi_wstrb = 4'hf;
        miscompares = 0;
        checked = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        check_reset;
        drive_out;
        read_in;
        analog_pins;
        osc_pins;
        shared_pins;
        reset_again;
        close_out;
    end
endmodule : tb_gpa_port
